// ==== verilog/cfg_port_pkg.sv ====
// Constants and types of the two-wire block-write configuration port
// Overview of operation
// RULE1: Host starts write with write address.
// RULE2: Acknowledge address, command, count, each data byte.
// RULE3: Host sends command, then count, then data.
// RULE4: Command and count bytes are discarded.
// RULE5: Host sends data from byte 0 upward.
// RULE6: Ascending order; early stop after any byte.
// RULE7: Load data bytes until stop arrives; the port loads bytes 0 to 7 only and discards later ones.
// RULE8: Host ends each write with stop.
// RULE9: Serial rate at most standard mode.
// RULE10: All transfers are whole 8-bit bytes.
// RULE11: Block write is the only write form.
// RULE12: Registers read back by block read.
// RULE13: Slave only; never drives serial clock.
// RULE14: Read: ack, count, bytes 0..7, stop.
// RULE15: Reset loads every byte with default.
// RULE16: Bytes 0 to 4 default all ones.
// RULE17: Enable bit one enables output pair.
// RULE18: Foreign address: no ack, line released.
package cfg_port_pkg;
  // ************************************************************
  // Protocol constants
  // ************************************************************
  localparam int          BYTE_W      = 8;
  localparam int          NUM_BYTES   = 8;
  localparam int          IDX_W       = 3;
  localparam int          PTR_W       = 4;
  localparam logic [7:0]  WR_ADDR     = 8'hd4;
  localparam logic [7:0]  RD_ADDR     = 8'hd5;
  localparam logic [7:0]  BYTE_RESET  = 8'hff;
  localparam logic [7:0]  READ_COUNT  = 8'h08;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam logic [3:0]  LAST_RD_PTR = 4'h8;
  localparam logic [3:0]  PTR_LIMIT   = 4'h8;
  localparam int          FIFO_DEPTH  = 4;
  localparam int          NUM_OUTS    = 6;
  // Shortest legal serial bit time and its length in reference cycles
  localparam int          REF_PERIOD_NS  = 4;
  localparam int          SCL_PERIOD_NS  = 10000;
  localparam int          SCL_PERIOD_CYC = SCL_PERIOD_NS / REF_PERIOD_NS;
  // Byte and bit of the enable for each differential output pair
  localparam int          EN_BYTE [NUM_OUTS] = '{5, 5, 5, 5, 6, 6};
  localparam int          EN_BIT  [NUM_OUTS] = '{7, 6, 3, 2, 3, 1};
  // Byte phases of a transaction
  localparam logic [1:0]  PH_ADDR  = 2'h0;
  localparam logic [1:0]  PH_CMD   = 2'h1;
  localparam logic [1:0]  PH_COUNT = 2'h2;
  localparam logic [1:0]  PH_DATA  = 2'h3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX     = 3'b011,
    ST_TX_ACK = 3'b100,
    ST_IGNORE = 3'b101
  } port_state_t;
endpackage : cfg_port_pkg

// ==== verilog/cfg_port.sv ====
// Byte FIFO and the two-wire slave port holding the output-control bytes
`timescale 1ns/10ps

// ************************************************************
// Small FIFO between the serial receiver and the register bytes
// ************************************************************
module byte_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [CW-1:0]               count;
  } fifo_state_t;

  fifo_state_t state_reg;
  fifo_state_t state_next;
  logic        do_push;
  logic        do_pop;

  // Handshake terms
  assign in_ready  = (state_reg.count != FULL_COUNT);
  assign out_valid = (state_reg.count != '0);
  assign out_data  = state_reg.mem[state_reg.rptr];
  assign do_push   = in_valid && in_ready;
  assign do_pop    = out_valid && out_ready;

  // Pointer and occupancy update
  always_comb
  begin
    state_next = state_reg;
    if (do_push)
    begin
      state_next.mem[state_reg.wptr] = in_data;
      state_next.wptr = (state_reg.wptr == LAST_SLOT) ? '0 : state_reg.wptr + 1'b1;
    end
    if (do_pop)
      state_next.rptr = (state_reg.rptr == LAST_SLOT) ? '0 : state_reg.rptr + 1'b1;
    if (do_push && !do_pop)
      state_next.count = state_reg.count + 1'b1;
    else if (!do_push && do_pop)
      state_next.count = state_reg.count - 1'b1;
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end
endmodule : byte_fifo

// ************************************************************
// Two-wire slave configuration port
// ************************************************************
module serial_block_write_config_port #(
  parameter int FIFO_DEPTH = cfg_port_pkg::FIFO_DEPTH
) (
  input  wire logic                             ref_clk,
  input  wire logic                             resetn,
  input  wire logic                             scl_in,
  input  wire logic                             serial_data_in,
  output logic                                  serial_data_out,
  output logic                                  serial_data_oe,
  output logic [cfg_port_pkg::NUM_OUTS-1:0]     out_enable
);
  localparam int ENTRY_W = cfg_port_pkg::IDX_W + cfg_port_pkg::BYTE_W;

  typedef struct packed {
    logic [2:0]                        scl_s;
    logic [2:0]                        sda_s;
    cfg_port_pkg::port_state_t         state;
    logic [1:0]                        phase;
    logic [2:0]                        bit_cnt;
    logic                              rx_full;
    logic [7:0]                        shift;
    logic                              is_read;
    logic                              host_ack;
    logic [cfg_port_pkg::PTR_W-1:0]    rd_ptr;
    logic [cfg_port_pkg::PTR_W-1:0]    wr_idx;
    logic                              sda_oe;
    logic                              sda_out;
    logic                              push;
    logic [ENTRY_W-1:0]                push_data;
    logic [cfg_port_pkg::NUM_BYTES-1:0][7:0] regs;
    logic [cfg_port_pkg::NUM_OUTS-1:0] out_en;
  } port_reg_t;

  port_reg_t          state_reg;
  port_reg_t          state_next;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               drain_ready;
  logic [ENTRY_W-1:0] fifo_out_data;
  logic               scl_rise;
  logic               scl_fall;
  logic               start_seen;
  logic               stop_seen;

  // Line events from the second and third sync stages only
  assign scl_rise   = state_reg.scl_s[1] && !state_reg.scl_s[2];
  assign scl_fall   = !state_reg.scl_s[1] && state_reg.scl_s[2];
  assign start_seen = state_reg.scl_s[1] && state_reg.scl_s[2]
                      && !state_reg.sda_s[1] && state_reg.sda_s[2];
  assign stop_seen  = state_reg.scl_s[1] && state_reg.scl_s[2]
                      && state_reg.sda_s[1] && !state_reg.sda_s[2];
  // Register writes pause while bytes are being shifted out
  assign drain_ready = (state_reg.state != cfg_port_pkg::ST_TX)
                       && (state_reg.state != cfg_port_pkg::ST_TX_ACK);

  // Outputs straight from flops; the clock line is only ever an input
  assign serial_data_out = state_reg.sda_out;   // RULE13
  assign serial_data_oe  = state_reg.sda_oe;
  assign out_enable      = state_reg.out_en;

  byte_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (state_reg.push),
    .in_ready  (fifo_in_ready),
    .in_data   (state_reg.push_data),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_out_data)
  );

  // Protocol engine, register bytes and output enables
  always_comb
  begin
    state_next          = state_reg;
    state_next.scl_s    = {state_reg.scl_s[1:0], scl_in};
    state_next.sda_s    = {state_reg.sda_s[1:0], serial_data_in};
    state_next.push     = 1'b0;
    state_next.sda_out  = 1'b0;
    // Drain one queued byte into its register per cycle
    if (fifo_out_valid && drain_ready)
      state_next.regs[fifo_out_data[ENTRY_W-1:cfg_port_pkg::BYTE_W]] =
        fifo_out_data[cfg_port_pkg::BYTE_W-1:0];   // RULE7
    if (stop_seen)
    begin
      state_next.state  = cfg_port_pkg::ST_IDLE;    // RULE6
      state_next.sda_oe = 1'b0;
    end
    else if (start_seen)
    begin
      state_next.state   = cfg_port_pkg::ST_RX;
      state_next.phase   = cfg_port_pkg::PH_ADDR;
      state_next.bit_cnt = '0;
      state_next.rx_full = 1'b0;
      state_next.wr_idx  = '0;
      state_next.rd_ptr  = '0;
      state_next.sda_oe  = 1'b0;
    end
    else
    begin
      unique case (state_reg.state)
        cfg_port_pkg::ST_IDLE,
        cfg_port_pkg::ST_IGNORE:
          state_next.sda_oe = 1'b0;   // RULE18
        cfg_port_pkg::ST_RX:
        begin
          // Sample on rising clock, decide on the falling edge after bit 8
          if (scl_rise && !state_reg.rx_full)
          begin
            state_next.shift   = {state_reg.shift[6:0], state_reg.sda_s[1]};   // RULE10
            state_next.bit_cnt = state_reg.bit_cnt + 1'b1;
            state_next.rx_full = (state_reg.bit_cnt == cfg_port_pkg::LAST_BIT);
          end
          else if (scl_fall && state_reg.rx_full)
          begin
            state_next.rx_full = 1'b0;
            state_next.state   = cfg_port_pkg::ST_RX_ACK;
            state_next.sda_oe  = 1'b1;   // RULE2
            unique case (state_reg.phase)
              cfg_port_pkg::PH_ADDR:
              begin
                state_next.phase   = cfg_port_pkg::PH_CMD;
                state_next.is_read = (state_reg.shift == cfg_port_pkg::RD_ADDR);
                if (state_reg.shift != cfg_port_pkg::WR_ADDR
                    && state_reg.shift != cfg_port_pkg::RD_ADDR)
                begin
                  state_next.state  = cfg_port_pkg::ST_IGNORE;   // RULE18
                  state_next.sda_oe = 1'b0;
                end
              end
              cfg_port_pkg::PH_CMD:
                state_next.phase = cfg_port_pkg::PH_COUNT;   // RULE4
              cfg_port_pkg::PH_COUNT:
                state_next.phase = cfg_port_pkg::PH_DATA;    // RULE4
              cfg_port_pkg::PH_DATA:
              begin
                if (state_reg.wr_idx < cfg_port_pkg::PTR_LIMIT)
                begin
                  if (fifo_in_ready)
                  begin
                    state_next.push      = 1'b1;   // RULE6
                    state_next.push_data = {state_reg.wr_idx[cfg_port_pkg::IDX_W-1:0],
                                            state_reg.shift};
                    state_next.wr_idx    = state_reg.wr_idx + 1'b1;
                  end
                  else
                  begin
                    state_next.state  = cfg_port_pkg::ST_IGNORE;
                    state_next.sda_oe = 1'b0;
                  end
                end
              end
            endcase
          end
        end
        cfg_port_pkg::ST_RX_ACK:
        begin
          // End of acknowledge: a read starts with the byte count
          if (scl_fall)
          begin
            state_next.bit_cnt = '0;
            if (state_reg.is_read)
            begin
              state_next.state  = cfg_port_pkg::ST_TX;   // RULE14
              state_next.shift  = cfg_port_pkg::READ_COUNT;
              state_next.sda_oe = !cfg_port_pkg::READ_COUNT[7];
            end
            else
            begin
              state_next.state  = cfg_port_pkg::ST_RX;   // RULE11
              state_next.sda_oe = 1'b0;
            end
          end
        end
        cfg_port_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            if (state_reg.bit_cnt == cfg_port_pkg::LAST_BIT)
            begin
              state_next.state  = cfg_port_pkg::ST_TX_ACK;
              state_next.sda_oe = 1'b0;
            end
            else
            begin
              state_next.bit_cnt = state_reg.bit_cnt + 1'b1;
              state_next.shift   = {state_reg.shift[6:0], 1'b0};
              state_next.sda_oe  = !state_reg.shift[6];
            end
          end
        end
        cfg_port_pkg::ST_TX_ACK:
        begin
          if (scl_rise)
            state_next.host_ack = !state_reg.sda_s[1];
          else if (scl_fall)
          begin
            state_next.bit_cnt = '0;
            if (state_reg.host_ack && state_reg.rd_ptr < cfg_port_pkg::LAST_RD_PTR)
            begin
              state_next.state  = cfg_port_pkg::ST_TX;   // RULE12
              state_next.shift  = state_reg.regs[state_reg.rd_ptr[cfg_port_pkg::IDX_W-1:0]];
              state_next.sda_oe = !state_next.shift[7];
              state_next.rd_ptr = state_reg.rd_ptr + 1'b1;   // RULE14
            end
            else
              state_next.state = cfg_port_pkg::ST_IGNORE;
          end
        end
        default:
          state_next.state = cfg_port_pkg::ST_IDLE;
      endcase
    end
    // Each enable bit gates one differential output pair
    for (int i = 0; i < cfg_port_pkg::NUM_OUTS; i++)
      state_next.out_en[i] =
        state_next.regs[cfg_port_pkg::EN_BYTE[i]][cfg_port_pkg::EN_BIT[i]];   // RULE17
  end

  // State register with power-on defaults
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_reg        <= '0;
      state_reg.scl_s  <= '1;
      state_reg.sda_s  <= '1;
      state_reg.regs   <= {cfg_port_pkg::NUM_BYTES{cfg_port_pkg::BYTE_RESET}};   // RULE15 RULE16
      state_reg.out_en <= '1;
    end
    else
      state_reg <= state_next;
  end
endmodule : serial_block_write_config_port

// ==== verification/cfg_port_checker.sv ====
// Pin-level assertions for the two-wire configuration port
`timescale 1ns/10ps
module cfg_port_checker (
  input wire logic                         ref_clk,
  input wire logic                         resetn,
  input wire logic                         scl_in,
  input wire logic                         serial_data_in,
  input wire logic                         serial_data_out,
  input wire logic                         serial_data_oe,
  input wire logic [cfg_port_pkg::NUM_OUTS-1:0] out_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ********
  // Bus tracking from the pins
  // ********
  logic       scl_q;
  logic       sda_q;
  logic       first_reg;
  logic [3:0] bit_reg;
  logic [7:0] addr_reg;
  wire rise     = scl_in & ~scl_q;
  wire start    = scl_in & scl_q & sda_q & ~serial_data_in;
  wire stop     = scl_in & scl_q & ~sda_q & serial_data_in;
  wire ack_rise = rise & (bit_reg == 4'h8);
  wire own      = (addr_reg[7:1] == 7'h6a);

  // Bit position in the byte and the address of the current transaction
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      first_reg <= 1'b0;
      bit_reg   <= 4'h0;
      addr_reg  <= 8'h00;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= serial_data_in;
      if (start || stop)
      begin
        first_reg <= start;
        bit_reg   <= 4'h0;
      end
      else if (rise)
      begin
        bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
        if (first_reg && bit_reg != 4'h8)
          addr_reg <= {addr_reg[6:0], serial_data_in};
        if (bit_reg == 4'h8)
          first_reg <= 1'b0;
      end
    end
  end

  // ********
  // Assertions
  // ********
  a_reset_state: assert property (disable iff (1'b0)
    !resetn |=> out_enable == 6'h3f && !serial_data_oe) else $error("bad reset state");
  a_drive_low: assert property (serial_data_out == 1'b0)
    else $error("data line driven high");
  a_oe_in_low: assert property ($changed(serial_data_oe) |-> !scl_in)
    else $error("data drive changed with clock high");
  a_addr_ack: assert property (ack_rise && first_reg && own |-> serial_data_oe)
    else $error("own address not acknowledged");
  a_write_ack: assert property (ack_rise && !first_reg && addr_reg == 8'hd4
    |-> serial_data_oe) else $error("write byte not acknowledged");
  a_read_release: assert property (ack_rise && !first_reg && addr_reg == 8'hd5
    |-> !serial_data_oe) else $error("host acknowledge slot not released");
  a_foreign_quiet: assert property (!first_reg && !own |-> !serial_data_oe)
    else $error("line driven for foreign address");
  a_stop_release: assert property (stop |-> !serial_data_oe)
    else $error("line driven at stop");
  a_write_only: assert property ($changed(out_enable) |-> addr_reg == 8'hd4)
    else $error("enables changed outside block write");
  c_write: cover property (ack_rise && !first_reg && addr_reg == 8'hd4);
  c_read: cover property (ack_rise && !first_reg && addr_reg == 8'hd5);
  c_foreign: cover property (ack_rise && first_reg && !own);
endmodule : cfg_port_checker

bind serial_block_write_config_port cfg_port_checker u_checker (.ref_clk(ref_clk),
  .resetn(resetn), .scl_in(scl_in), .serial_data_in(serial_data_in),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe), .out_enable(out_enable));

// ==== verification/serial_host_model.sv ====
// Serial bus controller model driving the configuration port
`timescale 1ns/10ps
module serial_host_model #(
  parameter int HALF_CYC = cfg_port_pkg::SCL_PERIOD_CYC / 2
) (
  input  wire logic ref_clk,
  input  wire logic sda_wire,
  output logic      scl_out,
  output logic      sda_pull_low
);
  // Bus idle at time zero: clock high, data released
  initial
  begin
    scl_out      = 1'b1;
    sda_pull_low = 1'b0;
  end

  // Waits n cycles and steps just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // Start or repeated start: data falls while clock high
  task automatic start_cond();
    sda_pull_low = 1'b0;
    tick(HALF_CYC);
    scl_out = 1'b1;
    tick(HALF_CYC);
    sda_pull_low = 1'b1;
    tick(HALF_CYC);
    scl_out = 1'b0;
  endtask : start_cond

  // Stop: data rises while clock high, only after a whole byte
  task automatic stop_cond();
    tick(4);
    sda_pull_low = 1'b1;
    tick(HALF_CYC);
    scl_out = 1'b1;
    tick(HALF_CYC);
    sda_pull_low = 1'b0;
    tick(HALF_CYC);
  endtask : stop_cond

  // Eight bits MSB first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic ack_drv,
                         output logic [7:0] rx, output logic ack_seen);
    logic [8:0] bits;
    logic [8:0] got;
    bits = {tx, ack_drv};
    for (int i = 8; i >= 0; i--)
    begin
      tick(4);
      sda_pull_low = ~bits[i];
      tick(HALF_CYC - 4);
      scl_out = 1'b1;
      tick(HALF_CYC);
      got[i] = sda_wire;
      scl_out = 1'b0;
    end
    rx = got[8:1];
    ack_seen = got[0];
  endtask : byte_io
endmodule : serial_host_model

// ==== verification/serial_block_write_config_port_test.sv ====
// Self-checking bench for the two-wire configuration port
`timescale 1ns/10ps
module serial_block_write_config_port_test;
  logic       ref_clk;
  logic       resetn;
  logic       scl;
  logic       sda_pull_low;
  logic       serial_data_out;
  logic       serial_data_oe;
  logic [5:0] out_enable;
  logic [7:0] mirror [8];
  logic [7:0] adr;
  logic [7:0] rx_b;
  logic       ack_b;
  int         err_total;
  int         tests_run;
  int         cycles;
  // Open-drain data line with pull-up
  wire sda_wire = (serial_data_oe ? serial_data_out : 1'b1) & ~sda_pull_low;

  serial_block_write_config_port uut (.ref_clk(ref_clk), .resetn(resetn), .scl_in(scl),
    .serial_data_in(sda_wire), .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe), .out_enable(out_enable));
  // Short bit time keeps the run small; the port only reacts to line edges
  serial_host_model #(.HALF_CYC(16)) host (.ref_clk(ref_clk), .sda_wire(sda_wire),
    .scl_out(scl), .sda_pull_low(sda_pull_low));

  // Clock and hang guard
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      err_total++;
      $display("ERROR at %0t: run timed out", $time);
      complete_run();
    end
  end

  // Compares one value and counts
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    tests_run++;
    if (seen !== want)
    begin
      err_total++;
      $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask : check

  // Pair enables from the byte image: byte5 bits 7,6,3,2 and byte6 bits 3,1
  function automatic logic [7:0] exp_enable();
    return {2'b00, mirror[6][1], mirror[6][3], mirror[5][2], mirror[5][3], mirror[5][6],
            mirror[5][7]};
  endfunction : exp_enable

  // Block write of n bytes from byte 0 upward; bytes past byte 7 are discarded
  task automatic write_block(input int n);
    logic [7:0] rx;
    logic       a;
    host.start_cond();
    host.byte_io(8'hd4, 1'b1, rx, a);
    check({7'h00, a}, 8'h00, "write address ack");
    for (int k = -2; k < n; k++)
    begin
      if (k >= 0 && k < 8)
        mirror[k] = 8'($urandom);
      host.byte_io((k < 0 || k > 7) ? 8'($urandom) : mirror[k], 1'b1, rx, a);
      check({7'h00, a}, 8'h00, "byte ack");
    end
    host.stop_cond();
    check({2'b00, out_enable}, exp_enable(), "enables");
  endtask : write_block

  // Block read of count byte and n data bytes, host refuses the last
  task automatic read_all(input int n);
    logic [7:0] rx;
    logic       a;
    host.start_cond();
    host.byte_io(8'hd5, 1'b1, rx, a);
    check({7'h00, a}, 8'h00, "read address ack");
    host.byte_io(8'hff, 1'b0, rx, a);
    check(rx, 8'h08, "byte count");
    for (int k = 0; k < n; k++)
    begin
      host.byte_io(8'hff, k == n - 1, rx, a);
      check(rx, mirror[k], "read data");
    end
    host.stop_cond();
  endtask : read_all

  // Reset held 4 cycles; image back to all ones
  task automatic do_reset();
    resetn = 1'b0;
    for (int k = 0; k < 8; k++)
      mirror[k] = 8'hff;
    repeat (4) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    check({2'b00, out_enable}, 8'h3f, "enables after reset");
  endtask : do_reset

  // Verdict and end of run
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // Main sequence
  initial
  begin
    void'($urandom(98037));
    do_reset();
    read_all(8);
    write_block(7);
    read_all(8);
    write_block(0);
    write_block(3);
    read_all(8);
    write_block(10);
    read_all(8);
    for (int t = 0; t < 4; t++)
    begin
      write_block(1 + $urandom_range(7));
      read_all(1 + $urandom_range(7));
    end
    for (int t = 0; t < 3; t++)
    begin
      adr = (t == 0) ? 8'hd6 : (t == 1) ? 8'h54 : 8'($urandom);
      if (adr[7:1] == 7'h6a)
        adr = 8'h00;
      host.start_cond();
      host.byte_io(adr, 1'b1, rx_b, ack_b);
      check({7'h00, ack_b}, 8'h01, "foreign address not acked");
      host.byte_io(8'h00, 1'b1, rx_b, ack_b);
      check({7'h00, ack_b}, 8'h01, "foreign address released");
      host.stop_cond();
    end
    do_reset();
    read_all(8);
    complete_run();
  end
endmodule : serial_block_write_config_port_test
